/* hdl/per_router.sv */
// Peripheral event router: tamper clear, clock fail-over, ADC triggers
// and one-word DMA requests. Assumes all producers share sys_clk except
// the tamper pins, the ADC trigger pin, and the calendar and timer increment events,
// which come from the slow or pin domain; all but the tamper pins are synchronised here.
`timescale 1ns/100ps
`include "per_map.svh"
module per_router
  import per_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [`PER_TAMPER_W-1:0] tamper_wake_pins,
  input wire logic tamper_enable,
  output logic backup_register_bank_clear,
  input wire logic xtal_fail,
  output logic mck_use_rc,
  input wire logic adc_external_trigger_pin,
  input wire logic [2:0] timer_counter_unit_out,
  input wire logic calendar_event_out0,
  input wire logic rt_timer_increment_event,
  output per_trig_t adc_trigger,
  input wire per_dma_t dma_req,
  output per_dma_t peripheral_dma_channels_word
);
  per_ck_t ck_state_r;
  logic [2:0] async_s1_r;
  logic [2:0] async_s2_r;
  logic [2:0] async_s3_r;
  logic [2:0] tc_r;
  per_dma_t dma_prev_r;

  // Purely combinational so the clear needs no clock edge [RL1] [RL6]
  assign backup_register_bank_clear = tamper_enable & (|tamper_wake_pins);

  // Clock fail-over is sticky until reset; a crystal that recovers
  // must not switch the master clock back silently [RL2]
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ck_state_r <= PER_CK_XTAL;
    end else begin
      case (ck_state_r)
        PER_CK_XTAL: if (xtal_fail) ck_state_r <= PER_CK_SWITCH; // [RL2]
        PER_CK_SWITCH: ck_state_r <= PER_CK_RC;
        PER_CK_RC: ck_state_r <= PER_CK_RC;
        default: ck_state_r <= PER_CK_RC;
      endcase
    end
  end

  // Switch request asserted from the cycle after failure is sampled on
  assign mck_use_rc = (ck_state_r != PER_CK_XTAL); // [RL2]

  // Three-flop synchronisers; only the third stage drives the ADC triggers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      async_s1_r <= 3'h0;
      async_s2_r <= 3'h0;
      async_s3_r <= 3'h0;
    end else begin
      async_s1_r <= {rt_timer_increment_event, calendar_event_out0,
                     adc_external_trigger_pin}; // [RL8]
      async_s2_r <= async_s1_r; // [RL8]
      async_s3_r <= async_s2_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tc_r <= 3'h0;
    end else begin
      tc_r <= timer_counter_unit_out;
    end
  end

  // All sources fan out in parallel; the ADC selects among them [RL3] [RL4]
  always_comb begin
    adc_trigger = '0;
    adc_trigger[`PER_TRIG_EXT] = async_s3_r[0]; // [RL3]
    adc_trigger[`PER_TRIG_TC0] = tc_r[0]; // [RL3]
    adc_trigger[`PER_TRIG_TC1] = tc_r[1]; // [RL3]
    adc_trigger[`PER_TRIG_TC2] = tc_r[2]; // [RL3]
    adc_trigger[`PER_TRIG_CAL0] = async_s3_r[1]; // [RL3]
    adc_trigger[`PER_TRIG_RTINC] = async_s3_r[2]; // [RL3]
  end

  // Rising edge of each request gives one single-cycle word strobe,
  // so a request held high still starts only one transfer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dma_prev_r <= '0;
    end else begin
      dma_prev_r <= dma_req;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PER_DMA_W; gi++) begin : g_dma
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          peripheral_dma_channels_word[gi] <= 1'b0;
        end else begin
          peripheral_dma_channels_word[gi] <=
            dma_req[gi] & ~dma_prev_r[gi]; // [RL5] [RL6]
        end
      end
    end
  endgenerate
endmodule

/* hdl/per_map.svh */
// Constants of the peripheral event router: field positions and counts.
// Assumes inclusion by the package and the router module only.
// Contract
// RL1: A tamper event on either wake-up pin clears the backup register bank at once, with no clock.
// RL2: A main crystal failure moves the master clock over to the internal RC oscillator.
// RL3: The external trigger pin, timer outputs 0 to 2, calendar output 0 and the timer increment reach the ADC as triggers.
// RL4: The ADC picks among its routed triggers itself; the router does not choose.
// RL5: Each transfer request pulse from a listed peripheral starts exactly one DMA word transfer.
// RL6: Events pass straight from producer to consumer with no processor action.
// RL7: Each consumer holds its own logic that selects which incoming event it heeds.
// RL8: Events from other clock domains are synchronised before use, except the asynchronous backup clear.
`ifndef PER_MAP_SVH
`define PER_MAP_SVH
`define PER_TAMPER_W 2
`define PER_TRIG_W 6
`define PER_TRIG_EXT 0
`define PER_TRIG_TC0 1
`define PER_TRIG_TC1 2
`define PER_TRIG_TC2 3
`define PER_TRIG_CAL0 4
`define PER_TRIG_RTINC 5
`define PER_DMA_W 13
`define PER_DMA_UART0 0
`define PER_DMA_UART1 1
`define PER_DMA_USART 2
`define PER_DMA_TWI0 3
`define PER_DMA_TWI1 4
`define PER_DMA_TWI2 5
`define PER_DMA_ADC 6
`define PER_DMA_TC 7
`define PER_DMA_SPI 8
`define PER_DMA_AUD0 9
`define PER_DMA_AUD1 10
`define PER_DMA_PDM0 11
`define PER_DMA_PDM1 12
`endif

/* hdl/per_pkg.sv */
// Types shared by the peripheral event router.
// Assumes per_map.svh is on the include path.
`include "per_map.svh"
package per_pkg;
  typedef enum logic [1:0] {PER_CK_XTAL, PER_CK_SWITCH, PER_CK_RC} per_ck_t;
  typedef logic [`PER_TRIG_W-1:0] per_trig_t;
  typedef logic [`PER_DMA_W-1:0] per_dma_t;
endpackage

/* verification/per_router_sva.sv */
// Port checker for per_router.
// Assumes it is bound onto every per_router instance.
`timescale 1ns/100ps
module per_router_sva import per_pkg::*; (
  input wire logic sys_clk, rstn, tamper_enable, xtal_fail, mck_use_rc,
  input wire logic backup_register_bank_clear, adc_external_trigger_pin,
  input wire logic calendar_event_out0, rt_timer_increment_event,
  input wire logic [1:0] tamper_wake_pins,
  input wire logic [2:0] timer_counter_unit_out,
  input wire per_trig_t adc_trigger,
  input wire per_dma_t dma_req, peripheral_dma_channels_word);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_tamper_clear_now:
    assert property (backup_register_bank_clear ==
      (tamper_enable & |tamper_wake_pins)) else $error("clear wrong");
  a_rc_switch_next:
    assert property (xtal_fail |=> mck_use_rc) else $error("no rc");
  a_rc_stays_on:
    assert property (mck_use_rc |=> mck_use_rc) else $error("rc lost");
  a_timer_trig_lag:
    assert property (adc_trigger[3:1] == $past(timer_counter_unit_out))
      else $error("timer trigger");
  a_pin_trig_sync:
    assert property (adc_trigger[0] == $past(adc_external_trigger_pin, 3))
      else $error("pin trigger");
  a_slow_trig_sync:
    assert property (adc_trigger[5:4] == {$past(rt_timer_increment_event, 3),
      $past(calendar_event_out0, 3)}) else $error("slow trigger");
  a_dma_one_word:
    assert property (peripheral_dma_channels_word ==
      ($past(dma_req) & ~$past(dma_req, 2))) else $error("dma word");
endmodule
bind per_router per_router_sva u_per_router_sva(.*);

/* verification/per_far_model.sv */
// Consumers: ADC trigger pick and DMA word count.
// Assumes router outputs on sys_clk.
`timescale 1ns/100ps
module per_far_model import per_pkg::*; (
  input wire logic sys_clk, rstn,
  input wire per_trig_t adc_trigger,
  input wire logic [2:0] trig_sel,
  input wire per_dma_t word,
  output logic adc_start,
  output int words_r);
  // The ADC alone chooses its trigger
  assign adc_start = adc_trigger[trig_sel];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) words_r <= 0;
    else words_r <= words_r + $countones(word);
  end
endmodule

/* verification/per_router_tb_top.sv */
// Bench: trigger rows, then tamper, fail-over and DMA cases.
// Assumes design and per_far_model compiled first.
`timescale 1ns/100ps
module per_router_tb_top import per_pkg::*; ;
  logic sys_clk = 0, rstn = 0, ten = 0, xf = 0, ext = 0, cal = 0, rti = 0;
  logic [1:0] pins = 0;
  logic [2:0] tc = 0, sel = 0;
  per_dma_t req = 0, word;
  per_trig_t trig;
  logic clr, rc, st;
  int words_r, errors = 0, checked = 0;
  logic [11:0] rows [6] = '{12'h041, 12'h082, 12'h104, 12'h208, 12'h410,
    12'h820};
  always #12.5 sys_clk = ~sys_clk;
  per_router u_per_router(.sys_clk, .rstn, .tamper_wake_pins(pins),
    .tamper_enable(ten), .backup_register_bank_clear(clr), .xtal_fail(xf),
    .mck_use_rc(rc), .adc_external_trigger_pin(ext),
    .timer_counter_unit_out(tc), .calendar_event_out0(cal),
    .rt_timer_increment_event(rti), .adc_trigger(trig), .dma_req(req),
    .peripheral_dma_channels_word(word));
  per_far_model u_per_far_model(.sys_clk, .rstn, .adc_trigger(trig),
    .trig_sel(sel), .word, .adc_start(st), .words_r);
  task automatic chk(input logic [11:0] g, e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    cyc(12);
    chk({rc, trig, 5'h00}, 12'h000);
    @(posedge sys_clk) rstn <= 1;
    foreach (rows[i]) begin
      @(posedge sys_clk) {rti, cal, tc, ext} <= rows[i][11:6];
      sel <= 3'(i);
      cyc(4);
      chk(12'({st, trig}), {5'h00, 1'b1, rows[i][5:0]});
    end
    for (int k = 1; k < 8; k++) begin
      @(posedge sys_clk) {ten, pins} <= 3'(k);
      #1 chk(12'(clr), 12'(k > 4));
    end
    @(posedge sys_clk) xf <= 1;
    @(posedge sys_clk) xf <= 0;
    cyc(3);
    chk(12'(rc), 12'h001);
    @(posedge sys_clk) req <= 13'h1fff;
    cyc(3);
    @(posedge sys_clk) req <= 13'h0000;
    @(posedge sys_clk) req <= 13'h1fff;
    @(posedge sys_clk) req <= 13'h0000;
    cyc(3);
    chk(12'(words_r), 12'h01a);
    summarize();
  end
  // Whole run is about 65 cycles; this margin is ample
  initial begin
    #20000;
    errors++;
    summarize();
  end
endmodule
